/* hw/rhc_pkg.sv */
// Package of constants for the drum read-head checker
// Contract
// - Check runs only in arithmetic wait cycles (arith_busy high)
// - Suppress drum data transfer during idle-check
// - Compare every head's data against pattern
// - Successive idle-check patterns alternate start bit
// - Any head mismatch drives failure indicator
package rhc_pkg;
    localparam int NUM_HEADS = 8;
    localparam int DATA_W = 16;
    localparam logic [15:0] PAT_ONE_FIRST = 16'hAAAA;
    localparam logic [15:0] PAT_ZERO_FIRST = 16'h5555;
    localparam logic PHASE_RESET = 1'b0;
    localparam logic FAIL_RESET = 1'b0;
    typedef enum logic [1:0] {
        RHC_IDLE = 2'b00,
        RHC_CHECK = 2'b01
    } rhc_state_t;
endpackage

/* hw/rhc_checker.sv */
// Dynamic read-head checker using idle-check instructions during arithmetic waits
`timescale 1ns/100ps

// Pattern select: the alternating word every head should return next
module rhc_pattern_sel (
    // Phase
    input wire logic one_first,
    // Selected pattern
    output logic [rhc_pkg::DATA_W-1:0] pattern
);
    always_comb begin
        if (one_first) begin
            pattern = rhc_pkg::PAT_ONE_FIRST;
        end else begin
            pattern = rhc_pkg::PAT_ZERO_FIRST;
        end
    end
endmodule

// Phase tracker: flips the expected starting bit after every checked word
module rhc_phase_track (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Checked-word strobe
    input wire logic step,
    // High when the next word starts with a one
    output logic one_first
);
    logic next_one_first;

    always_comb begin
        next_one_first = one_first;
        if (step) begin
            next_one_first = !one_first;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            one_first <= ~rhc_pkg::PHASE_RESET;
        end else begin
            one_first <= next_one_first;
        end
    end
endmodule

// Transfer gate: holds off drum data while an idle-check word is on the heads
module rhc_xfer_gate (
    // Request side
    input wire logic req,
    input wire logic idle_word,
    // Gated enable
    output logic en
);
    assign en = req && !idle_word;
endmodule

// One head's comparator: flags a word that differs from the expected pattern
module rhc_head_cmp #(
    parameter int WIDTH = 16
) (
    // Qualifier
    input wire logic enable,
    // Word under test and its reference
    input wire logic [WIDTH-1:0] word,
    input wire logic [WIDTH-1:0] pattern,
    // Result
    output logic mismatch
);
    logic differs;

    assign differs = (word != pattern);
    assign mismatch = enable && differs;
endmodule

// Sticky flag: a set in the same cycle as a clear wins
module rhc_sticky_bit (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Controls
    input wire logic set,
    input wire logic clear,
    // Flag
    output logic flag
);
    logic next_flag;

    always_comb begin
        next_flag = flag;
        if (clear) begin
            next_flag = 1'b0;
        end
        if (set) begin
            next_flag = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            flag <= rhc_pkg::FAIL_RESET;
        end else begin
            flag <= next_flag;
        end
    end
endmodule

// Top of the checker: comparators, sticky failure flags and pattern phase
module rhc_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Sequencer side
    input wire logic idle_check_instruction,
    input wire logic arith_busy,
    input wire logic drum_xfer_req,
    output logic drum_xfer_en,
    // Drum heads, one data word per head
    input wire logic [rhc_pkg::NUM_HEADS*rhc_pkg::DATA_W-1:0] head_data,
    // Panel
    input wire logic fail_clear,
    output logic head_fail,
    output logic [rhc_pkg::NUM_HEADS-1:0] head_fail_map,
    output logic expect_one_first
);
    // Check strobe and its parts
    logic word_strobe;
    logic arith_wait;
    logic check_now;
    logic clear_now;

    // Expected word and the word of each head
    logic [rhc_pkg::DATA_W-1:0] expected;
    logic [rhc_pkg::DATA_W-1:0] head_word [rhc_pkg::NUM_HEADS];

    // Per-head results
    logic [rhc_pkg::NUM_HEADS-1:0] mism;
    logic any_mism;
    logic [rhc_pkg::NUM_HEADS-1:0] map_flag;
    logic fail_flag;
    logic phase;

    // Only words that fall in an arithmetic wait are checked
    assign word_strobe = idle_check_instruction;
    assign arith_wait = arith_busy;
    assign check_now = word_strobe && arith_wait;
    assign clear_now = fail_clear;

    rhc_xfer_gate u_xfer_gate (
        .req(drum_xfer_req),
        .idle_word(idle_check_instruction),
        .en(drum_xfer_en)
    );

    rhc_phase_track u_phase (
        .mclk(mclk),
        .rst_n(rst_n),
        .step(check_now),
        .one_first(phase)
    );

    rhc_pattern_sel u_pattern (
        .one_first(phase),
        .pattern(expected)
    );

    // Split the head bus into one word per head
    genvar w;
    generate
        for (w = 0; w < rhc_pkg::NUM_HEADS; w++) begin : g_word
            assign head_word[w] = head_data[w*rhc_pkg::DATA_W +: rhc_pkg::DATA_W];
        end
    endgenerate

    genvar h;
    generate
        for (h = 0; h < rhc_pkg::NUM_HEADS; h++) begin : g_cmp
            rhc_head_cmp #(
                .WIDTH(rhc_pkg::DATA_W)
            ) u_cmp (
                .enable(check_now),
                .word(head_word[h]),
                .pattern(expected),
                .mismatch(mism[h])
            );
        end
    endgenerate

    assign any_mism = |mism;

    // One sticky flag per head so the panel shows which head misread
    genvar m;
    generate
        for (m = 0; m < rhc_pkg::NUM_HEADS; m++) begin : g_map
            rhc_sticky_bit u_map (
                .mclk(mclk),
                .rst_n(rst_n),
                .set(mism[m]),
                .clear(clear_now),
                .flag(map_flag[m])
            );
        end
    endgenerate

    rhc_sticky_bit u_fail (
        .mclk(mclk),
        .rst_n(rst_n),
        .set(any_mism),
        .clear(clear_now),
        .flag(fail_flag)
    );

    assign head_fail_map = map_flag;
    assign head_fail = fail_flag;
    assign expect_one_first = phase;
endmodule

/* testbench/rhc_checker_assertions.sv */
// Port assertions for the read-head checker
`timescale 1ns/100ps
module rhc_checker_assertions(input wire logic mclk, rst_n, idle_check_instruction,
    arith_busy, drum_xfer_req, drum_xfer_en, fail_clear, head_fail, expect_one_first,
    input wire logic [127:0] head_data,
    input wire logic [7:0] head_fail_map);
    logic check;
    logic [15:0] pattern;
    logic [7:0] bad;
    assign check = idle_check_instruction && arith_busy;
    assign pattern = expect_one_first ? rhc_pkg::PAT_ONE_FIRST : rhc_pkg::PAT_ZERO_FIRST;
    for (genvar i = 0; i < 8; i++) begin : g_bad
        assign bad[i] = check && (head_data[i*16 +: 16] != pattern);
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_bad_word;
        bad != 8'h00;
    endsequence
    sequence s_clean_clear;
        fail_clear && bad == 8'h00;
    endsequence
    AST_FAIL_SET: assert property (s_bad_word |=> head_fail)
        else $error("fail flag not set");
    AST_MAP_SET: assert property (s_bad_word |=> (head_fail_map & $past(bad)) == $past(bad))
        else $error("head map bit not set");
    AST_CLEAR: assert property (s_clean_clear |=> !head_fail && head_fail_map == 8'h00)
        else $error("clear did not clear");
    AST_QUIET: assert property (!check && !fail_clear |=> $stable(head_fail_map))
        else $error("map changed outside a check");
    AST_XFER: assert property (drum_xfer_en == (drum_xfer_req && !idle_check_instruction))
        else $error("xfer");
    AST_PHASE: assert property (1 |=> $changed(expect_one_first) == $past(idle_check_instruction && arith_busy))
        else $error("phase");
    AST_HOLD: assert property (head_fail && !fail_clear |=> head_fail) else $error("hold");
endmodule

/* testbench/rhc_heads.sv */
// Drum heads model
`timescale 1ns/100ps
module rhc_heads(input wire logic ph, input wire logic [127:0] flip, output logic [127:0] hd);
    logic [15:0] pat;
    assign pat = ph ? rhc_pkg::PAT_ONE_FIRST : rhc_pkg::PAT_ZERO_FIRST;
    assign hd = {rhc_pkg::NUM_HEADS{pat}} ^ flip;
endmodule

/* testbench/testbench.sv */
// Bench for the read-head checker
`timescale 1ns/100ps
module testbench;
    logic mclk = 0, rst_n = 0, ic = 0, bsy = 0, req = 0, clr = 0, ph = 1, xen, hf, eof;
    logic [127:0] flip = 0, hd;
    logic [7:0] map;
    int miscompares = 0, tests_run = 0;
    rhc_checker u_rhc_checker(.mclk, .rst_n, .idle_check_instruction(ic), .arith_busy(bsy),
        .drum_xfer_req(req), .drum_xfer_en(xen), .head_data(hd), .fail_clear(clr),
        .head_fail(hf), .head_fail_map(map), .expect_one_first(eof));
    rhc_heads u_rhc_heads(.ph, .flip, .hd);
    task chk(input logic [8:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task word(input logic b);
        @(negedge mclk) {ic, bsy} = {1'b1, b};
        #1 chk(xen, 1'b0);
        @(negedge mclk) {ic, bsy} = 0;
        ph ^= b;
        #1 chk(eof, ph);
        chk(xen, req);
    endtask
    task s_burst;
        @(negedge mclk) {ic, bsy} = 2'b11;
        @(negedge mclk) ph ^= 1'b1;
        #1 chk(eof, ph);
        @(negedge mclk) {ic, bsy} = 0;
        ph ^= 1'b1;
        #1 chk(eof, ph);
        chk({hf, map}, 9'h000);
    endtask
    task s_refused;
        req = 0;
        flip = {128{1'b1}};
        word(0);
        chk({hf, map}, 9'h000);
        flip = 0;
        req = 1;
    endtask
    task s_fail;
        flip = 128'h1 << 32;
        word(1);
        chk({hf, map}, 9'h104);
        flip = 0;
        word(1);
        chk({hf, map}, 9'h104);
        @(negedge mclk) clr = 1;
        @(negedge mclk) clr = 0;
        #1 chk({hf, map}, 9'h000);
    endtask
    task s_set_wins;
        flip = 128'h1 << 112;
        @(negedge mclk) {ic, bsy, clr} = 3'b111;
        @(negedge mclk) {ic, bsy, clr} = 0;
        ph ^= 1'b1;
        flip = 0;
        #1 chk({hf, map}, 9'h180);
        chk(eof, ph);
    endtask
    task s_reset;
        @(negedge mclk) rst_n = 0;
        @(negedge mclk) rst_n = 1;
        ph = 1;
        #1 chk({hf, map}, 9'h000);
        chk(eof, 1'b1);
        word(1);
        chk({hf, map}, 9'h000);
    endtask
    task end_sim;
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial forever #12.5 mclk = ~mclk;
    initial begin
        repeat (6) @(negedge mclk);
        rst_n = 1;
        req = 1;
        #1 chk({hf, map}, 9'h000);
        chk(eof, 1'b1);
        s_burst;
        repeat (3) word(1);
        word(0);
        chk(hf, 0);
        s_refused;
        s_fail;
        s_set_wins;
        s_reset;
        end_sim;
    end
endmodule
bind rhc_checker rhc_checker_assertions u_rhc_checker_assertions(.*);
